// ==== core/fcs_regs.svh ====
// Constants of the clock synthesis control block: offsets, fields, counts.
// Assumes a 32-bit Avalon-MM slave with byte addresses on 8 bits.
//
// Contract
// [RULE_01] Four inputs; with external feedback off all four may be chosen.
// [RULE_02] Software selects exactly one input as the synthesis reference.
// [RULE_03] Clock and feedback paths each have a loss detector on a prescaler.
// [RULE_04] The host checks the loss alarms before it goes on reprogramming.
// [RULE_05] The loop feedback ratio is held inside the oscillator's range.
// [RULE_06] Output dividers alternate two integer ratios for exact average.
// [RULE_07] The divider tracks its phase error and corrects its edges.
// [RULE_08] Fractional mode keeps the output at most oscillator over eight.
// [RULE_09] Bypass mode offers only the integer ratios four and six.
// [RULE_10] The host uses at most the quarter and sixth above one eighth.
// [RULE_11] Each output frequency steps up or down by a chosen increment.
// [RULE_12] Each output phase steps by a chosen amount.
// [RULE_13] The selected reference can drive an output directly.
// [RULE_14] One interrupt shows unmasked loss of lock or loss of signal.
// [RULE_15] Enable and steps come from software or optionally from pins.
// [RULE_16] The stored configuration is applied after every power up.
// [RULE_17] A loss alarm sets after a window without edges, clears on edge.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// Register byte offsets
`define FCS_OFF_CTRL    8'h00
`define FCS_OFF_STATUS  8'h04
`define FCS_OFF_OUTEN   8'h08
`define FCS_OFF_CMD     8'h0c
`define FCS_OFF_FBDIV   8'h10
`define FCS_OFF_RATIO   8'h20
`define FCS_OFF_STEP    8'h30
`define FCS_OFF_PSTEP   8'h40
// Control fields
`define FCS_CTRL_EXTFB  2
`define FCS_CTRL_PINS   3
`define FCS_CTRL_MSKC   4
`define FCS_CTRL_MSKF   5
`define FCS_CTRL_MSKL   6
// Reset values and limits
`define FCS_RATIO_RST   32'h00a00000
`define FCS_FBDIV_RST   12'h064
`define FCS_FB_MIN      12'h010
`define FCS_FB_MAX      12'h800
`define FCS_MS_MIN      12'h008
`define FCS_BYP_LO      12'h004
`define FCS_BYP_HI      12'h006
`define FCS_LOS_WIN     8'h40
`endif

// ==== core/fcs_pkg.sv ====
// Types of the clock synthesis control block.
// Assumes fcs_regs.svh is included by the design that uses them.
package fcs_pkg;
  // Whole state of the control block
  typedef struct packed {
    logic [11:0]       s1;
    logic [11:0]       s2;
    logic [11:0]       s3;
    logic              loaded;
    logic              wait_r;
    logic [31:0]       rdata;
    logic [7:0]        ctrl;
    logic [15:0]       outen;
    logic [11:0]       fbdiv;
    logic [3:0][31:0]  ratio;
    logic [3:0][19:0]  step;
    logic [3:0][7:0]   pstep;
    logic [3:0][19:0]  acc;
    logic [3:0][13:0]  cnt;
    logic [3:0]        oclk;
    logic [1:0][7:0]   los_cnt;
    logic [1:0]        los;
    logic              intr;
    logic              synth_ref;
    logic [1:0]        eff_sel;
  } fcs_state_t;
endpackage : fcs_pkg

// ==== core/fcs_ctrl.sv ====
// Control logic of a four-output fractional clock synthesiser.
// Assumes prescaler outputs, lock and control pins are asynchronous.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fcs_ctrl
  import fcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Inputs and prescaler outputs
  input  wire logic [3:0]  REF_IN,
  input  wire logic        CLOCK_INPUT_PRESCALER,
  input  wire logic        FEEDBACK_INPUT_PRESCALER,
  input  wire logic        PLL_LOCKED,
  // Optional control pins
  input  wire logic        OE_PIN,
  input  wire logic        FINC_PIN,
  input  wire logic        FDEC_PIN,
  input  wire logic        PINC_PIN,
  input  wire logic        PDEC_PIN,
  // Stored default configuration
  input  wire logic [7:0]  NVM_CTRL,
  input  wire logic [15:0] NVM_OUTEN,
  // Results
  output logic             SYNTH_REF,
  output logic      [1:0]  REF_SEL,
  output logic      [11:0] FB_RATIO,
  output logic      [3:0]  OUT_CLK,
  output logic             CLOCK_INPUT_LOSS_ALARM,
  output logic             FEEDBACK_INPUT_LOSS_ALARM,
  output logic             INTR
);

  fcs_state_t st_reg;
  fcs_state_t st_next;

  logic [11:0] pins;
  logic [11:0] rise;
  logic [1:0]  edg;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic [15:0] cmd;
  logic [1:0]  ch;
  logic [11:0] int_eff;
  logic [19:0] frac_eff;
  logic [20:0] sum;
  logic [31:0] rt;
  logic [13:0] ph;
  logic        oe_all;

  // Pin order kept by the synchroniser
  assign pins = {REF_IN, CLOCK_INPUT_PRESCALER, FEEDBACK_INPUT_PRESCALER,
                 PLL_LOCKED, OE_PIN, FINC_PIN, FDEC_PIN, PINC_PIN,
                 PDEC_PIN};

  // Byte lanes to bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0;
    ch     = AVS_ADDRESS[3:2];
    unique case (AVS_ADDRESS[7:4])
      4'h0: begin
        if (AVS_ADDRESS[3:2] == 2'h0) begin
          rd_mux = {24'h0, st_reg.ctrl};
        end else if (AVS_ADDRESS[3:2] == 2'h1) begin
          rd_mux = {26'h0, st_reg.loaded, st_reg.eff_sel,
                    ~st_reg.s2[5], st_reg.los};
        end else if (AVS_ADDRESS[3:2] == 2'h2) begin
          rd_mux = {16'h0, st_reg.outen};
        end
      end
      4'h1: begin
        if (AVS_ADDRESS[3:2] == 2'h0) begin
          rd_mux = {20'h0, st_reg.fbdiv};
        end
      end
      4'h2: rd_mux = st_reg.ratio[ch];
      4'h3: rd_mux = {12'h0, st_reg.step[ch]};
      4'h4: rd_mux = {24'h0, st_reg.pstep[ch]};
      default: rd_mux = 32'h0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_next  = st_reg;
    rise     = 12'h0;
    edg      = 2'h0;
    cmd      = 16'h0;
    int_eff  = 12'h0;
    frac_eff = 20'h0;
    sum      = 21'h0;
    rt       = 32'h0;
    ph       = 14'h0;
    oe_all   = 1'b1;
    if (CE) begin
      // Two flip-flops before use, third stage for edges
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      rise = st_reg.s2 & ~st_reg.s3;
      edg  = st_reg.s2[7:6] ^ st_reg.s3[7:6];

      // Stored configuration taken once after reset
      if (!st_reg.loaded) begin
        st_next.loaded = 1'b1;                     // [RULE_16]
        st_next.ctrl   = NVM_CTRL;                 // [RULE_16]
        st_next.outen  = NVM_OUTEN;                // [RULE_16]
      end

      // Bus slave: one wait cycle, then the access completes
      if (st_reg.wait_r) begin
        if ((AVS_READ || AVS_WRITE) && st_reg.loaded) begin
          st_next.wait_r = 1'b0;
          st_next.rdata  = rd_mux;
        end
      end else begin
        st_next.wait_r = 1'b1;
        if (AVS_WRITE) begin
          unique case (AVS_ADDRESS[7:4])
            4'h0: begin
              if (ch == 2'h0) begin
                st_next.ctrl = (st_reg.ctrl & ~wmask[7:0]) |
                               (AVS_WRITEDATA[7:0] & wmask[7:0]); // [RULE_02]
              end else if (ch == 2'h2) begin
                st_next.outen = (st_reg.outen & ~wmask[15:0]) |
                                (AVS_WRITEDATA[15:0] & wmask[15:0]);
              end else if (ch == 2'h3) begin
                cmd = AVS_WRITEDATA[15:0] & wmask[15:0];  // [RULE_15]
              end
            end
            4'h1: begin
              if (ch == 2'h0) begin
                rt[11:0] = (st_reg.fbdiv & ~wmask[11:0]) |
                           (AVS_WRITEDATA[11:0] & wmask[11:0]);
                // Keep the oscillator inside its range
                if (rt[11:0] < `FCS_FB_MIN) begin
                  st_next.fbdiv = `FCS_FB_MIN;             // [RULE_05]
                end else if (rt[11:0] > `FCS_FB_MAX) begin
                  st_next.fbdiv = `FCS_FB_MAX;             // [RULE_05]
                end else begin
                  st_next.fbdiv = rt[11:0];
                end
              end
            end
            4'h2: st_next.ratio[ch] = (st_reg.ratio[ch] & ~wmask) |
                                      (AVS_WRITEDATA & wmask);
            4'h3: st_next.step[ch] = (st_reg.step[ch] & ~wmask[19:0]) |
                                     (AVS_WRITEDATA[19:0] & wmask[19:0]);
            4'h4: st_next.pstep[ch] = (st_reg.pstep[ch] & ~wmask[7:0]) |
                                      (AVS_WRITEDATA[7:0] & wmask[7:0]);
            default: ;
          endcase
        end
      end

      // Pin edges act on all four outputs in pin control
      if (st_reg.ctrl[`FCS_CTRL_PINS]) begin
        oe_all = st_reg.s2[4];                             // [RULE_15]
        cmd = cmd | {{4{rise[0]}}, {4{rise[1]}},
                     {4{rise[2]}}, {4{rise[3]}}};          // [RULE_15]
      end

      // Reference selector; feedback inputs kept out in external feedback
      if (st_reg.ctrl[`FCS_CTRL_EXTFB]) begin
        st_next.eff_sel = {1'b0, st_reg.ctrl[0]};          // [RULE_01]
      end else begin
        st_next.eff_sel = st_reg.ctrl[1:0];                // [RULE_01]
      end
      st_next.synth_ref = st_reg.s2[8 + st_reg.eff_sel];   // [RULE_02]

      // Loss detectors on the two prescaler outputs
      for (int d = 0; d < 2; d++) begin
        if (edg[d]) begin
          st_next.los_cnt[d] = 8'h0;                       // [RULE_17]
          st_next.los[d]     = 1'b0;                       // [RULE_17]
        end else if (st_reg.los_cnt[d] == `FCS_LOS_WIN - 8'h1) begin
          st_next.los[d]     = 1'b1;                       // [RULE_03]
        end else begin
          st_next.los_cnt[d] = st_reg.los_cnt[d] + 8'h1;
        end
      end

      // Masked interrupt from loss of signal and loss of lock
      st_next.intr = (st_reg.los[1] & ~st_reg.ctrl[`FCS_CTRL_MSKC]) |
                     (st_reg.los[0] & ~st_reg.ctrl[`FCS_CTRL_MSKF]) |
                     (~st_reg.s2[5] & ~st_reg.ctrl[`FCS_CTRL_MSKL]); // [RULE_14]

      // Output dividers, one per channel
      for (int i = 0; i < 4; i++) begin
        // Frequency steps move the ratio by the chosen increment
        rt = st_next.ratio[i];
        if (cmd[i]) begin
          rt = rt - {12'h0, st_reg.step[i]};               // [RULE_11]
        end
        if (cmd[4 + i]) begin
          rt = rt + {12'h0, st_reg.step[i]};               // [RULE_11]
        end
        st_next.ratio[i] = rt;
        // Integer part and fraction in use
        if (st_reg.outen[8 + i]) begin
          int_eff  = st_reg.outen[12 + i] ? `FCS_BYP_HI
                                          : `FCS_BYP_LO;  // [RULE_09]
          frac_eff = 20'h0;                                // [RULE_09]
        end else begin
          int_eff  = (st_reg.ratio[i][31:20] < `FCS_MS_MIN) ? `FCS_MS_MIN
                     : st_reg.ratio[i][31:20];             // [RULE_08]
          frac_eff = st_reg.ratio[i][19:0];
        end
        ph = st_reg.cnt[i];
        // Phase steps shift the next edge
        if (cmd[8 + i]) begin
          ph = ph + {6'h0, st_reg.pstep[i]};               // [RULE_12]
        end
        if (cmd[12 + i]) begin
          ph = (ph > {6'h0, st_reg.pstep[i]})
               ? ph - {6'h0, st_reg.pstep[i]} : 14'h0;     // [RULE_12]
        end
        if (!(st_reg.outen[i] && oe_all)) begin
          st_next.oclk[i] = 1'b0;
          st_next.cnt[i]  = 14'h0;
        end else if (st_reg.outen[4 + i]) begin
          st_next.oclk[i] = st_reg.synth_ref;              // [RULE_13]
        end else if (ph == 14'h0) begin
          // Carry of the accumulated error picks the longer ratio
          sum = {1'b0, st_reg.acc[i]} + {1'b0, frac_eff};  // [RULE_06]
          st_next.acc[i]  = sum[19:0];                     // [RULE_07]
          st_next.cnt[i]  = {2'h0, int_eff} + {13'h0, sum[20]}
                            - 14'h1;                       // [RULE_06]
          st_next.oclk[i] = ~st_reg.oclk[i];
        end else begin
          st_next.cnt[i] = ph - 14'h1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg         <= '0;
      st_reg.wait_r  <= 1'b1;
      st_reg.fbdiv   <= `FCS_FBDIV_RST;
      st_reg.ratio   <= {4{`FCS_RATIO_RST}};
      st_reg.s1[5]   <= 1'b1;
      st_reg.s2[5]   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign AVS_READDATA              = st_reg.rdata;
  assign AVS_WAITREQUEST           = st_reg.wait_r;
  assign SYNTH_REF                 = st_reg.synth_ref;
  assign REF_SEL                   = st_reg.eff_sel;
  assign FB_RATIO                  = st_reg.fbdiv;
  assign OUT_CLK                   = st_reg.oclk;
  assign CLOCK_INPUT_LOSS_ALARM    = st_reg.los[1];
  assign FEEDBACK_INPUT_LOSS_ALARM = st_reg.los[0];
  assign INTR                      = st_reg.intr;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_extfb_sel;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && st_reg.ctrl[`FCS_CTRL_EXTFB]) |=> !REF_SEL[1];
  endproperty
  a_extfb_sel: assert property (p_extfb_sel) // [RULE_01]
    else $error("Feedback input chosen in external feedback");

  property p_ref_sel;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && !st_reg.ctrl[`FCS_CTRL_EXTFB])
        |=> REF_SEL == $past(st_reg.ctrl[1:0]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) // [RULE_02]
    else $error("Reference selection not followed");

  property p_los_set;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && !edg[1] && st_reg.los_cnt[1] == `FCS_LOS_WIN - 8'h1)
        |=> CLOCK_INPUT_LOSS_ALARM;
  endproperty
  a_los_set: assert property (p_los_set) // [RULE_17]
    else $error("Loss alarm missing after quiet window");

  property p_los_clr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && edg[0]) |=> !FEEDBACK_INPUT_LOSS_ALARM;
  endproperty
  a_los_clr: assert property (p_los_clr) // [RULE_03]
    else $error("Loss alarm kept despite an edge");

  property p_frac_min;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && st_reg.outen[0] && !st_reg.outen[4] && !st_reg.outen[8]
       && oe_all && !cmd[8] && st_reg.cnt[0] == 14'h0)
        |=> st_reg.cnt[0] >= 14'h7;
  endproperty
  a_frac_min: assert property (p_frac_min) // [RULE_08]
    else $error("Fractional ratio below eight");

  property p_bypass;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && st_reg.outen[1] && !st_reg.outen[5] && st_reg.outen[9]
       && oe_all && !cmd[9] && st_reg.cnt[1] == 14'h0)
        |=> st_reg.cnt[1] == 14'h3 || st_reg.cnt[1] == 14'h5;
  endproperty
  a_bypass: assert property (p_bypass) // [RULE_09]
    else $error("Bypass ratio not four or six");

  property p_toggle;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && st_reg.outen[2] && !st_reg.outen[6] && oe_all
       && !cmd[10] && st_reg.cnt[2] == 14'h0)
        |=> OUT_CLK[2] != $past(OUT_CLK[2]);
  endproperty
  a_toggle: assert property (p_toggle) // [RULE_06]
    else $error("Divider edge missing at terminal count");

  property p_intr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && st_reg.los[1] && !st_reg.ctrl[`FCS_CTRL_MSKC]) |=> INTR;
  endproperty
  a_intr: assert property (p_intr) // [RULE_14]
    else $error("Unmasked loss did not raise interrupt");

  property p_nvm;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CE && RST_N && !st_reg.loaded)
        |=> st_reg.loaded && st_reg.outen == $past(NVM_OUTEN);
  endproperty
  a_nvm: assert property (p_nvm) // [RULE_16]
    else $error("Stored configuration not applied");

endmodule : fcs_ctrl

// ==== verif/fcs_src_model.sv ====
// Far side model: prescaler outputs and loop lock seen by the block.
// Assumes the bench drives run bits; edges run unrelated to core clock.
`timescale 1ns/1ns
module fcs_src_model (
  // Run controls
  input  wire logic [2:0] run,
  // Prescaler outputs and lock
  output logic            clk_pre,
  output logic            fb_pre,
  output logic            locked
);
  // ----------------------------------------------------------
  // Prescaler edges, halted to create a loss of signal
  // ----------------------------------------------------------
  initial begin
    clk_pre = 1'b0;
    fb_pre  = 1'b1;
  end
  // Both prescalers are always toggling unless stopped
  always #31 if (run[0]) clk_pre = ~clk_pre;
  always #37 if (run[1]) fb_pre = ~fb_pre;
  // Lock follows its run bit
  assign locked = run[2];
endmodule : fcs_src_model

// ==== verif/fractional_clock_synth_control_test.sv ====
// Testbench of the clock synthesis control block over Avalon-MM.
// Assumes the source model and the design's register constants.
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fractional_clock_synth_control_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic        waitreq;
  logic [3:0]  ref_in = 4'h0;
  logic [2:0]  run = 3'h7;
  logic        clk_pre;
  logic        fb_pre;
  logic        locked;
  logic        oe_pin = 1'b1;
  logic        finc = 1'b0;
  logic        fdec = 1'b0;
  logic        synth_ref;
  logic [1:0]  ref_sel;
  logic [11:0] fb_ratio;
  logic [3:0]  out_clk;
  logic [1:0]  alarm;
  logic        intr;
  int          n_mismatch = 0;
  int          compares = 0;
  int          t;
  logic [31:0] v;
  logic [31:0] fbw [3] = '{32'h001, 32'hfff, 32'h123};
  logic [31:0] fbe [3] = '{32'h010, 32'h800, 32'h123};
  logic [31:0] stb [3] = '{32'h2, 32'h1, 32'h4};

  // ----------------------------------------------------------
  // Clock, design and source model
  // ----------------------------------------------------------
  always #10 clk = ~clk;
  fcs_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce),
    .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .REF_IN(ref_in), .CLOCK_INPUT_PRESCALER(clk_pre),
    .FEEDBACK_INPUT_PRESCALER(fb_pre), .PLL_LOCKED(locked),
    .OE_PIN(oe_pin), .FINC_PIN(finc), .FDEC_PIN(fdec),
    .PINC_PIN(1'b0), .PDEC_PIN(1'b0), .NVM_CTRL(8'h01),
    .NVM_OUTEN(16'h000f), .SYNTH_REF(synth_ref),
    .REF_SEL(ref_sel), .FB_RATIO(fb_ratio), .OUT_CLK(out_clk),
    .CLOCK_INPUT_LOSS_ALARM(alarm[1]),
    .FEEDBACK_INPUT_LOSS_ALARM(alarm[0]), .INTR(intr));
  fcs_src_model src (.run(run), .clk_pre(clk_pre),
    .fb_pre(fb_pre), .locked(locked));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One bus access held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= w;
    rd_s  <= ~w;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    v = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : bus

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Count toggles of one output over n settled samples
  task tog(input int ch, input int n, output int k);
    logic p;
    k = 0;
    #1;
    p = out_clk[ch];
    repeat (n) begin
      @(posedge clk);
      #1;
      if (out_clk[ch] !== p) k++;
      p = out_clk[ch];
    end
    // Return on a rising edge so that stimulus follows on the edge
    @(posedge clk);
  endtask : tog

  task end_of_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    // Stored defaults and reset values
    bus(0, `FCS_OFF_CTRL, 0);
    chk(v, 32'h01);
    bus(0, `FCS_OFF_OUTEN, 0);
    chk(v, 32'h0f);
    chk(32'(ref_sel), 32'h1);
    bus(0, `FCS_OFF_RATIO, 0);
    chk(v, `FCS_RATIO_RST);
    chk(32'(intr), 32'h0);
    tog(0, 200, t);
    chk(32'(t), 32'd20);
    // Unmapped and command reads
    bus(1, 8'h7c, 32'hffffffff);
    bus(0, 8'h7c, 0);
    chk(v, 32'h0);
    bus(0, `FCS_OFF_CMD, 0);
    chk(v, 32'h0);
    // Feedback ratio clamp
    for (int i = 0; i < 3; i++) begin
      bus(1, `FCS_OFF_FBDIV, fbw[i]);
      bus(0, `FCS_OFF_FBDIV, 0);
      chk(v, fbe[i]);
      chk(32'(fb_ratio), fbe[i]);
    end
    // Every reference selection
    for (int s = 0; s < 4; s++) begin
      bus(1, `FCS_OFF_CTRL, 32'(s));
      ref_in <= 4'h1 << s;
      cyc(6);
      chk(32'(ref_sel), 32'(s));
      chk(32'(synth_ref), 32'h1);
      ref_in <= ~(4'h1 << s);
      cyc(6);
      chk(32'(synth_ref), 32'h0);
    end
    bus(1, `FCS_OFF_CTRL, 32'h07);
    cyc(3);
    chk(32'(ref_sel[1]), 32'h0);
    bus(1, `FCS_OFF_CTRL, 32'h00);
    // Loss of clock, feedback and lock, unmasked then masked
    for (int i = 0; i < 3; i++) begin
      run <= 3'h7 & ~(3'h1 << i);
      cyc(40);
      chk(32'(alarm), 32'h0);
      cyc(40);
      // Host confirms the alarms before going on
      bus(0, `FCS_OFF_STATUS, 0);
      chk(v & 32'h7, stb[i]);
      chk(32'(alarm), stb[i] & 32'h3);
      chk(32'(intr), 32'h1);
      bus(1, `FCS_OFF_CTRL, 32'h10 << i);
      cyc(3);
      chk(32'(intr), 32'h0);
      run <= 3'h7;
      cyc(12);
      chk(32'(alarm), 32'h0);
      bus(1, `FCS_OFF_CTRL, 32'h00);
    end
    // Fractional ratio and frequency steps
    bus(1, `FCS_OFF_RATIO, 32'h00880000);
    cyc(40);
    tog(0, 170, t);
    chk(32'(t), 32'd20);
    bus(1, `FCS_OFF_STEP, 32'h00080000);
    bus(1, `FCS_OFF_CMD, 32'h1);
    bus(0, `FCS_OFF_RATIO, 0);
    chk(v, 32'h00800000);
    bus(1, `FCS_OFF_CMD, 32'h10);
    bus(0, `FCS_OFF_RATIO, 0);
    chk(v, 32'h00880000);
    bus(1, `FCS_OFF_RATIO, 32'h00300000);
    cyc(40);
    tog(0, 160, t);
    chk(32'(t), 32'd20);
    // Bypass uses only quarter and sixth
    bus(1, `FCS_OFF_OUTEN, 32'h030f);
    cyc(20);
    tog(0, 48, t);
    chk(32'(t), 32'd12);
    tog(1, 48, t);
    chk(32'(t), 32'd12);
    bus(1, `FCS_OFF_OUTEN, 32'h330f);
    cyc(20);
    tog(0, 48, t);
    chk(32'(t), 32'd8);
    // Pin control of enable and frequency step
    bus(1, `FCS_OFF_OUTEN, 32'h000f);
    bus(1, `FCS_OFF_CTRL, 32'h08);
    bus(1, `FCS_OFF_STEP + 8'h04, 32'h1);
    oe_pin <= 1'b0;
    cyc(8);
    tog(0, 40, t);
    chk(32'(t), 32'd0);
    oe_pin <= 1'b1;
    finc <= 1'b1;
    cyc(8);
    finc <= 1'b0;
    bus(0, `FCS_OFF_RATIO + 8'h04, 0);
    chk(v, 32'h009fffff);
    fdec <= 1'b1;
    cyc(8);
    fdec <= 1'b0;
    bus(0, `FCS_OFF_RATIO + 8'h04, 0);
    chk(v, 32'h00a00000);
    bus(1, `FCS_OFF_CTRL, 32'h00);
    // Reference straight to output one
    bus(1, `FCS_OFF_OUTEN, 32'h002f);
    for (int l = 0; l < 2; l++) begin
      ref_in <= 4'(l);
      cyc(8);
      chk(32'(out_clk[1]), 32'(l));
    end
    // Byte lanes and phase step field width
    be <= 4'h2;
    bus(1, `FCS_OFF_OUTEN, 32'hffffffff);
    be <= 4'hf;
    bus(0, `FCS_OFF_OUTEN, 0);
    chk(v, 32'h0000ff2f);
    bus(1, `FCS_OFF_PSTEP, 32'hffffffff);
    bus(0, `FCS_OFF_PSTEP, 0);
    chk(v, 32'h000000ff);
    // Clock enable low freezes the outputs
    bus(1, `FCS_OFF_OUTEN, 32'h000f);
    cyc(20);
    ce <= 1'b0;
    tog(0, 40, t);
    chk(32'(t), 32'd0);
    ce <= 1'b1;
    // A phase delay of 255 cycles holds channel zero still
    bus(1, `FCS_OFF_CMD, 32'h100);
    tog(0, 200, t);
    chk(32'(t), 32'd0);
    end_of_test();
  end

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
endmodule : fractional_clock_synth_control_test
